// ===== hdl/rtca_pkg.sv
package rtca_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_STAGE0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_MATCH0 = 8'h08;
	localparam logic [7:0] ADDR_ROUTE = 8'h0C;
	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int CTL_OSC_EN = 7;
	localparam int CTL_MCD_EN = 6;
	localparam int CTL_OSC_FAIL = 5;
	localparam int CTL_RUN = 4;
	localparam int CTL_ALM_EN = 3;
	localparam int CTL_ALM_FLAG = 2;
	localparam int CTL_SET = 1;
	localparam int CTL_CAP = 0;
	// ----------------------------------------
	// alarm route fields
	// ----------------------------------------
	localparam int RTE_IRQ = 0;
	localparam int RTE_WAKE = 1;
	localparam int RTE_RESET = 2;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [2:0] ROUTE_RST = 3'h0;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int MISS_TIME_NS = 100_000;
	localparam int MISS_CYC = MISS_TIME_NS / CLK_PERIOD_NS;
endpackage

// ===== hdl/rtca_clk_sync.sv
`timescale 1ns/10ps
module rtca_clk_sync (
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o,
	output logic change_o
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	// meta_ff feeds sync_ff only
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign level_o = sync_ff;
	assign rise_o = sync_ff & ~prev_ff;
	assign change_o = sync_ff ^ prev_ff;
endmodule

// ===== hdl/rtca_alarm_ctrl.sv
`timescale 1ns/10ps
module rtca_alarm_ctrl
	import rtca_pkg::*;
#(
	parameter int TIMER_W = 32
) (
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic SLOW_CLK_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	output logic OSC_ENABLE_O,
	output logic ALARM_FLAG_O,
	output logic ALARM_IRQ_O,
	output logic ALARM_WAKE_O,
	output logic ALARM_RESET_O,
	output logic OSC_FAIL_O
);
	localparam logic [10:0] MISS_LIM = 11'(MISS_CYC);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic byte_hit(input logic [7:0] addr, input logic [7:0] base, input int idx);
		byte_hit = (addr == (base + 8'(idx)));
	endfunction

	// ----------------------------------------
	// slow clock synchroniser
	// ----------------------------------------
	logic tick;
	logic slow_change;

	// slow clock must run well below the core clock or edges are lost
	rtca_clk_sync u_sync (
		.CLK_I(CLK_I),
		.SRST_I(SRST_I),
		.async_i(SLOW_CLK_I),
		.level_o(),
		.rise_o(tick),
		.change_o(slow_change)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic osc_en_ff;
	logic mcd_en_ff;
	logic osc_fail_ff;
	logic run_ff;
	logic alm_en_ff;
	logic alm_flag_ff;
	logic auto_rst_ff;
	logic set_ff;
	logic cap_ff;
	logic [2:0] route_ff;
	logic [TIMER_W-1:0] timer_ff;
	logic [TIMER_W-1:0] stage_ff;
	logic [TIMER_W-1:0] match_ff;
	logic [10:0] miss_cnt_ff;
	logic [7:0] rdata_ff;

	logic nxt_osc_fail;
	logic nxt_alm_flag;
	logic nxt_set;
	logic nxt_cap;
	logic [TIMER_W-1:0] nxt_timer;
	logic [TIMER_W-1:0] nxt_stage;
	logic [TIMER_W-1:0] nxt_match;
	logic [10:0] nxt_miss_cnt;
	logic [7:0] nxt_rdata;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire wr_ctrl = WR_I & (ADDR_I == ADDR_CTRL);
	wire wr_route = WR_I & (ADDR_I == ADDR_ROUTE);
	wire alm_disable = wr_ctrl & ~WDATA_I[CTL_ALM_EN];
	wire match_hit = (timer_ff == match_ff);
	wire alarm_fire = tick & alm_en_ff & ~alm_disable & ~alm_flag_ff & match_hit;
	wire auto_clear = tick & alm_flag_ff & auto_rst_ff;
	wire miss_fire = mcd_en_ff & ~slow_change & (miss_cnt_ff == MISS_LIM);
	wire [7:0] ctrl_rd = {osc_en_ff, mcd_en_ff, osc_fail_ff, run_ff, alm_en_ff, alm_flag_ff, set_ff, cap_ff};

	// ----------------------------------------
	// timer path
	// ----------------------------------------
	always_comb begin
		nxt_timer = timer_ff;
		if (set_ff) begin
			nxt_timer = stage_ff;
		end else if (auto_clear) begin
			nxt_timer = '0;
		end else if (tick & run_ff) begin
			nxt_timer = timer_ff + 1'b1;
		end
	end

	// flag lives one slow cycle; disabling wins over a coincident match
	always_comb begin
		nxt_alm_flag = alm_flag_ff;
		if (alm_disable) begin
			nxt_alm_flag = 1'b0;
		end else if (alarm_fire) begin
			nxt_alm_flag = 1'b1;
		end else if (tick) begin
			nxt_alm_flag = 1'b0;
		end
	end

	// ----------------------------------------
	// staging and match registers
	// ----------------------------------------
	// a bus byte written in the capture cycle wins over the copy
	always_comb begin
		nxt_stage = cap_ff ? timer_ff : stage_ff;
		nxt_match = match_ff;
		for (int i = 0; i < 4; i++) begin
			if (WR_I & byte_hit(ADDR_I, ADDR_STAGE0, i)) begin
				nxt_stage[8*i +: 8] = WDATA_I;
			end
			if (WR_I & byte_hit(ADDR_I, ADDR_MATCH0, i)) begin
				nxt_match[8*i +: 8] = WDATA_I;
			end
		end
	end

	// ----------------------------------------
	// missing clock detector
	// ----------------------------------------
	// counter parks one above the limit, so one stall flags once
	always_comb begin
		if (~mcd_en_ff | slow_change) begin
			nxt_miss_cnt = 11'h000;
		end else if (miss_cnt_ff <= MISS_LIM) begin
			nxt_miss_cnt = miss_cnt_ff + 11'h001;
		end else begin
			nxt_miss_cnt = miss_cnt_ff;
		end
	end

	// software writes one to request; a fresh request beats completion
	assign nxt_set = wr_ctrl & WDATA_I[CTL_SET];
	assign nxt_cap = wr_ctrl & WDATA_I[CTL_CAP];
	assign nxt_osc_fail = miss_fire | (osc_fail_ff & ~(wr_ctrl & ~WDATA_I[CTL_OSC_FAIL]));

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		nxt_rdata = 8'h00;
		if (RD_I) begin
			for (int i = 0; i < 4; i++) begin
				if (byte_hit(ADDR_I, ADDR_STAGE0, i)) begin
					nxt_rdata = stage_ff[8*i +: 8];
				end
				if (byte_hit(ADDR_I, ADDR_MATCH0, i)) begin
					nxt_rdata = match_ff[8*i +: 8];
				end
			end
			if (ADDR_I == ADDR_CTRL) begin
				nxt_rdata = ctrl_rd;
			end
			if (ADDR_I == ADDR_ROUTE) begin
				nxt_rdata = {5'h00, route_ff};
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			{osc_en_ff, mcd_en_ff, run_ff, alm_en_ff, auto_rst_ff} <= CTRL_RST[4:0];
			osc_fail_ff <= 1'b0;
			set_ff <= 1'b0;
			cap_ff <= 1'b0;
			route_ff <= ROUTE_RST;
		end else begin
			if (wr_ctrl) begin
				osc_en_ff <= WDATA_I[CTL_OSC_EN];
				mcd_en_ff <= WDATA_I[CTL_MCD_EN];
				run_ff <= WDATA_I[CTL_RUN];
				alm_en_ff <= WDATA_I[CTL_ALM_EN];
				auto_rst_ff <= WDATA_I[CTL_ALM_FLAG];
			end
			if (wr_route) begin
				route_ff <= WDATA_I[2:0];
			end
			osc_fail_ff <= nxt_osc_fail;
			set_ff <= nxt_set;
			cap_ff <= nxt_cap;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			alm_flag_ff <= 1'b0;
			timer_ff <= WORD_RST;
			stage_ff <= WORD_RST;
			match_ff <= WORD_RST;
			miss_cnt_ff <= 11'h000;
			rdata_ff <= 8'h00;
		end else begin
			alm_flag_ff <= nxt_alm_flag;
			timer_ff <= nxt_timer;
			stage_ff <= nxt_stage;
			match_ff <= nxt_match;
			miss_cnt_ff <= nxt_miss_cnt;
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign RDATA_O = rdata_ff;
	assign OSC_ENABLE_O = osc_en_ff;
	assign ALARM_FLAG_O = alm_flag_ff;
	assign ALARM_IRQ_O = alm_flag_ff & route_ff[RTE_IRQ];
	assign ALARM_WAKE_O = alm_flag_ff & route_ff[RTE_WAKE];
	assign ALARM_RESET_O = alm_flag_ff & route_ff[RTE_RESET];
	assign OSC_FAIL_O = osc_fail_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_alarm_on_match: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(tick && alm_en_ff && !wr_ctrl && !alm_flag_ff && timer_ff == match_ff) |=> alm_flag_ff)
		else $error("alarm flag missing after match");

	chk_flag_one_tick: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(alm_flag_ff && tick) |=> !alm_flag_ff)
		else $error("alarm flag outlived one slow cycle");

	chk_autoreset_zero: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(alm_flag_ff && tick && auto_rst_ff && !set_ff) |=> (timer_ff == '0))
		else $error("auto reset did not clear timer");

	chk_timer_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(!run_ff && !set_ff && !auto_clear) |=> $stable(timer_ff))
		else $error("stopped timer changed");

	chk_timer_step: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(run_ff && tick && !set_ff && !auto_clear) |=> (timer_ff == $past(timer_ff) + 1'b1))
		else $error("running timer did not step by one");

	chk_disable_clears: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(WR_I && ADDR_I == ADDR_CTRL && !WDATA_I[CTL_ALM_EN]) |=> (!alm_flag_ff && !alm_en_ff))
		else $error("alarm disable left flag set");

	chk_set_load: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(WR_I && ADDR_I == ADDR_CTRL && WDATA_I[CTL_SET]) |=> set_ff ##1 (timer_ff == $past(stage_ff)))
		else $error("set did not load staging value");

	chk_cap_copy: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(cap_ff && !(WR_I && ADDR_I[7:2] == 6'h00)) |=> (stage_ff == $past(timer_ff)))
		else $error("capture did not copy timer");

	chk_miss_detect: assert property (@(posedge CLK_I) disable iff (SRST_I)
		miss_fire |=> osc_fail_ff)
		else $error("missing clock not flagged");

	chk_flag_readback: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(RD_I && ADDR_I == ADDR_CTRL) |=> (RDATA_O[CTL_ALM_FLAG] == $past(alm_flag_ff)))
		else $error("bit 2 read does not show alarm flag");

	// ----------------------------------------
	// register invariants
	// ----------------------------------------
	chk_flag_needs_match: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(!alm_flag_ff && !(tick && alm_en_ff && timer_ff == match_ff)) |=> !alm_flag_ff)
		else $error("alarm flag rose without a match");

	chk_flag_quiet_off: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(!alm_en_ff && !alm_flag_ff) |=> !alm_flag_ff)
		else $error("alarm flag rose while alarms disabled");

	chk_timer_plain: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(!auto_rst_ff && !set_ff && !(tick && run_ff)) |=> $stable(timer_ff))
		else $error("timer moved without tick, set or auto reset");

	chk_timer_wrap: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(run_ff && tick && !set_ff && !auto_clear && timer_ff == '1) |=> (timer_ff == '0))
		else $error("timer did not wrap to zero");

	chk_set_done: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(set_ff && !(wr_ctrl && WDATA_I[CTL_SET])) |=> !set_ff)
		else $error("set bit not cleared after load");

	chk_cap_done: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(cap_ff && !(wr_ctrl && WDATA_I[CTL_CAP])) |=> !cap_ff)
		else $error("capture bit not cleared after copy");

	chk_stage_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(!cap_ff && !(WR_I && ADDR_I[7:2] == 6'h00)) |=> $stable(stage_ff))
		else $error("staging value changed without capture or write");

	chk_match_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
		!(WR_I && ADDR_I[7:2] == 6'h02) |=> $stable(match_ff))
		else $error("match value changed without a write");

	chk_fail_sticky: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(osc_fail_ff && !(wr_ctrl && !WDATA_I[CTL_OSC_FAIL])) |=> osc_fail_ff)
		else $error("oscillator fail dropped without a clear");

	chk_fail_clear: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(wr_ctrl && !WDATA_I[CTL_OSC_FAIL] && !miss_fire) |=> !osc_fail_ff)
		else $error("oscillator fail not cleared by write");

	chk_fail_needs_en: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(!mcd_en_ff && !osc_fail_ff) |=> !osc_fail_ff)
		else $error("oscillator fail set with detector off");

	chk_fail_not_early: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(!osc_fail_ff && miss_cnt_ff != MISS_LIM) |=> !osc_fail_ff)
		else $error("oscillator fail set before stall time");

	chk_osc_on: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(wr_ctrl && WDATA_I[CTL_OSC_EN]) |=> OSC_ENABLE_O)
		else $error("oscillator enable not set");

	chk_osc_off: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(wr_ctrl && !WDATA_I[CTL_OSC_EN]) |=> !OSC_ENABLE_O)
		else $error("oscillator enable not cleared");

	chk_run_stop: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(wr_ctrl && !WDATA_I[CTL_RUN]) |=> !run_ff)
		else $error("run bit not cleared");

	chk_auto_on: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(wr_ctrl && WDATA_I[CTL_ALM_FLAG]) |=> auto_rst_ff)
		else $error("bit 2 write did not enable auto reset");

	chk_auto_off: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(wr_ctrl && !WDATA_I[CTL_ALM_FLAG]) |=> !auto_rst_ff)
		else $error("bit 2 write did not disable auto reset");
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
	import rtca_pkg::*;
	logic CLK_I = 1'b0;
	logic SRST_I = 1'b1;
	logic SLOW_CLK_I = 1'b0;
	logic [7:0] ADDR_I = 8'h00;
	logic [7:0] WDATA_I = 8'h00;
	logic WR_I = 1'b0;
	logic RD_I = 1'b0;
	wire logic [7:0] RDATA_O;
	wire logic OSC_ENABLE_O;
	wire logic ALARM_FLAG_O;
	wire logic ALARM_IRQ_O;
	wire logic ALARM_WAKE_O;
	wire logic ALARM_RESET_O;
	wire logic OSC_FAIL_O;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int rises = 0;
	int hi_len = 0;
	int max_len = 0;
	logic [31:0] t;
	logic [31:0] v;
	logic [7:0] b;

	rtca_alarm_ctrl #(.TIMER_W(32)) rtca_alarm_ctrl_i (.CLK_I(CLK_I), .SRST_I(SRST_I), .SLOW_CLK_I(SLOW_CLK_I),
		.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
		.OSC_ENABLE_O(OSC_ENABLE_O), .ALARM_FLAG_O(ALARM_FLAG_O), .ALARM_IRQ_O(ALARM_IRQ_O),
		.ALARM_WAKE_O(ALARM_WAKE_O), .ALARM_RESET_O(ALARM_RESET_O), .OSC_FAIL_O(OSC_FAIL_O));

	// ----------------------------------------
	// clock, watchdog, flag monitor
	// ----------------------------------------
	always #50 CLK_I = ~CLK_I;
	always @(posedge CLK_I) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count = err_count + 1;
			stop_test();
		end
	end
	// length of each flag pulse, in core cycles
	always @(posedge CLK_I) begin
		if (ALARM_FLAG_O === 1'b1) begin
			rises <= rises + int'(hi_len == 0);
			hi_len <= hi_len + 1;
		end else begin
			hi_len <= 0;
		end
		if (hi_len > max_len) begin
			max_len <= hi_len;
		end
	end

	// ----------------------------------------
	// tasks and functions
	// ----------------------------------------
	function automatic logic [31:0] tick_exp(input logic [31:0] s, input int n);
		return s + 32'(n);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			err_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge CLK_I);
		WR_I <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1 d = RDATA_O;
	endtask
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		for (int i = 0; i < 4; i++) begin
			wr(a + 8'(i), d[8*i+:8]);
		end
	endtask
	task automatic rd32(input logic [7:0] a, output logic [31:0] d);
		logic [7:0] x;
		for (int i = 0; i < 4; i++) begin
			rd(a + 8'(i), x);
			d[8*i+:8] = x;
		end
	endtask
	// slow clock only moves here, 8 core cycles a period
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge CLK_I);
			SLOW_CLK_I <= 1'b1;
			repeat (4) @(posedge CLK_I);
			SLOW_CLK_I <= 1'b0;
			repeat (3) @(posedge CLK_I);
		end
	endtask
	task automatic set_timer(input logic [31:0] val, input logic [7:0] ctl);
		wr32(ADDR_STAGE0, val);
		wr(ADDR_CTRL, ctl | 8'h02);
		repeat (3) @(posedge CLK_I);
	endtask
	task automatic get_timer(input logic [7:0] ctl, output logic [31:0] val);
		wr(ADDR_CTRL, ctl | 8'h01);
		repeat (3) @(posedge CLK_I);
		rd32(ADDR_STAGE0, val);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		v = $urandom(14482);
		repeat (6) @(posedge CLK_I);
		SRST_I <= 1'b0;
		rd(ADDR_CTRL, b);
		check(b, CTRL_RST);
		rd(ADDR_ROUTE, b);
		check(b, ROUTE_RST);
		rd32(ADDR_MATCH0, v);
		check(v, WORD_RST);
		check(OSC_FAIL_O, 1'b0);
		$display("test reset done");
		wr(ADDR_CTRL, 8'h80);
		check(OSC_ENABLE_O, 1'b1);
		wr(ADDR_CTRL, 8'h00);
		check(OSC_ENABLE_O, 1'b0);
		wr(ADDR_ROUTE, 8'h05);
		rd(ADDR_ROUTE, b);
		check(b, 8'h05);
		wr(8'h20, 8'hFF);
		rd(8'h20, b);
		check(b, 8'h00);
		$display("test registers done");
		t = $urandom();
		set_timer(t, 8'h00);
		rd(ADDR_CTRL, b);
		check(b[CTL_SET], 1'b0);
		get_timer(8'h00, v);
		check(v, t);
		rd(ADDR_CTRL, b);
		check(b[CTL_CAP], 1'b0);
		// corner: start one below the top so the count wraps
		set_timer(32'hFFFF_FFFE, 8'h80);
		wr(ADDR_CTRL, 8'h90);
		ticks(5);
		get_timer(8'h90, v);
		check(v, tick_exp(32'hFFFF_FFFE, 5));
		wr(ADDR_CTRL, 8'h80);
		ticks(3);
		get_timer(8'h80, v);
		check(v, tick_exp(32'hFFFF_FFFE, 5));
		$display("test timer done");
		t = $urandom();
		set_timer(t, 8'h80);
		wr32(ADDR_MATCH0, t + 32'h3);
		wr(ADDR_CTRL, 8'h98);
		ticks(3);
		check(rises, 0);
		ticks(1);
		check(ALARM_FLAG_O, 1'b1);
		check({ALARM_RESET_O, ALARM_WAKE_O, ALARM_IRQ_O}, 3'h5);
		rd(ADDR_CTRL, b);
		check(b[CTL_ALM_FLAG], 1'b1);
		wr(ADDR_CTRL, 8'h90);
		check(ALARM_FLAG_O, 1'b0);
		check({ALARM_RESET_O, ALARM_WAKE_O, ALARM_IRQ_O}, 3'h0);
		wr(ADDR_CTRL, 8'h98);
		ticks(4);
		check(rises, 1);
		$display("test alarm done");
		t = $urandom();
		set_timer(t, 8'h80);
		wr32(ADDR_MATCH0, t + 32'h1);
		wr(ADDR_CTRL, 8'h9C);
		ticks(4);
		get_timer(8'h9C, v);
		check(v, tick_exp(32'h0, 1));
		rd(ADDR_CTRL, b);
		check(b[CTL_ALM_FLAG], 1'b0);
		check(max_len, 8);
		check(rises, 2);
		// interval of five ticks: match programmed two below it
		set_timer(32'h0, 8'h80);
		wr32(ADDR_MATCH0, 32'h3);
		wr(ADDR_CTRL, 8'h9C);
		ticks(5);
		get_timer(8'h9C, v);
		check(v, 32'h0);
		check(rises, 3);
		$display("test auto reset done");
		wr(ADDR_CTRL, 8'hC0);
		ticks(1);
		repeat (MISS_CYC - 50) @(posedge CLK_I);
		check(OSC_FAIL_O, 1'b0);
		repeat (100) @(posedge CLK_I);
		check(OSC_FAIL_O, 1'b1);
		rd(ADDR_CTRL, b);
		check(b[CTL_OSC_FAIL], 1'b1);
		wr(ADDR_CTRL, 8'h80);
		check(OSC_FAIL_O, 1'b0);
		$display("test missing clock done");
		stop_test();
	end
endmodule
